// File: core/dram_dec_pkg.sv
// constants, register map and state type for the dram module decode and control
// assumes a single 250 MHz clock and an AXI4-Lite register bus
package dram_dec_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 4;
  localparam int T_ARB_NS = 100;
  localparam int T_REF_NS = 575;
  localparam int T_REFINT_NS = 14500;
  localparam int T_RC_NS = 40;
  localparam int T_CAS_NS = 120;
  localparam int ARB_CYC = (T_ARB_NS + CLK_NS - 1) / CLK_NS;
  localparam int REF_CYC = (T_REF_NS + CLK_NS - 1) / CLK_NS;
  localparam int REFINT_CYC = T_REFINT_NS / CLK_NS;
  localparam int RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAS_CYC = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  // ****************************************
  // addressing
  // ****************************************
  localparam int ADDR_W = 18;
  localparam int BANK_LSB = 13;
  localparam int BANK_W = 5;
  localparam int MUX_W = 7;
  localparam int ROW_CNT_W = 7;
  localparam int MODEL_TWO_RANGES = 0;
  localparam int MODEL_BIG_CHIPS = 1;
  // ****************************************
  // registers
  // ****************************************
  localparam logic [7:0] CFG_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam int CFG_BASE_LSB = 0;
  localparam int CFG_MODEL_LSB = 5;
  localparam int CFG_B7EN_BIT = 7;
  localparam int CFG_PAR_BIT = 8;
  localparam int STAT_ROW_LSB = 0;
  localparam int STAT_HIT_BIT = 8;
  localparam int STAT_BUSY_BIT = 9;
  localparam int STAT_WR_BIT = 10;
  localparam int STAT_EXT_BIT = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_REFRESH, ST_ROW, ST_COL, ST_REPLY, ST_HOLD} ctl_state_t;
endpackage : dram_dec_pkg

// File: core/dram_module_address_decode_control.sv
// address decode, array select and cycle timing for a word-wide dram module
// assumes asynchronous bus pins, one 250 MHz clock and an AXI4-Lite register port
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
module dram_module_address_decode_control #(
  parameter int REFINT_CYC = dram_dec_pkg::REFINT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [17:0] bus_addr_n,
  input wire logic bus_sync_n,
  input wire logic bus_din_n,
  input wire logic bus_dout_n,
  input wire logic bus_write_byte_flag_n,
  input wire logic bus_top_bank_sel_n,
  input wire logic bus_addr_bit12_n,
  input wire logic bus_refresh_req_n,
  output logic bus_reply_n,
  output logic row_strobe_lower_n,
  output logic row_strobe_upper_n,
  output logic col_strobe_a_n,
  output logic col_strobe_b_n,
  output logic hi_byte_write_n,
  output logic lo_byte_write_n,
  output logic [6:0] row_col_addr_bus,
  output logic parity_row_strobe_n,
  output logic parity_col_strobe_n,
  output logic cycle_busy_lock_n,
  output logic ext_refresh_seen
);
  localparam int ARB_HOLD = dram_dec_pkg::ARB_CYC - 1;
  localparam int REF_HOLD = dram_dec_pkg::REF_CYC - 1;
  localparam int PIN_W = 25;
  localparam logic [PIN_W-1:0] PIN_IDLE = {7'h7f, 18'h3ffff};

  dram_dec_pkg::ctl_state_t state;
  dram_dec_pkg::ctl_state_t next_state;
  logic [PIN_W-1:0] pins_s;
  logic [17:0] addr_now;
  logic sync_act, din_act, dout_act, wflag_act, top_sel, bit12_hi, sync_d;
  logic [31:0] cfg;
  logic [4:0] base;
  logic two_ranges, big_chips, b7en, par_en;
  logic [4:0] bank_off, size_banks;
  logic inhibit, hit_now;
  logic [17:0] cap_addr;
  logic cap_hit, cap_low, read_cycle_ff, write_cycle_ff, byte_mode, byte_now, wr_now;
  logic read_req, write_req, ref_req, acc_req, ref_done;
  logic [6:0] ref_row;
  logic [13:0] chip_addr;
  logic [6:0] row_part, col_part;
  logic [dram_dec_pkg::CNT_W-1:0] cnt;
  logic cnt_end;
  logic aw_held, w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  if (REFINT_CYC < dram_dec_pkg::REF_CYC + dram_dec_pkg::ARB_CYC)
  begin : g_bad_interval
    $error("refresh interval shorter than one refresh and arbitration");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  pin_sync #(.WIDTH(PIN_W), .RESET_VAL(PIN_IDLE)) u_pins (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins({bus_sync_n, bus_din_n, bus_dout_n, bus_write_byte_flag_n, bus_top_bank_sel_n,
           bus_addr_bit12_n, bus_refresh_req_n, bus_addr_n}),
    .synced(pins_s)
  );

  assign addr_now = ~pins_s[17:0];
  assign sync_act = !pins_s[24];
  assign din_act = !pins_s[23];
  assign dout_act = !pins_s[22];
  assign wflag_act = !pins_s[21];
  assign top_sel = !pins_s[20];
  assign bit12_hi = !pins_s[19];
  assign ext_refresh_seen = !pins_s[18];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sync_d <= 1'b0;
    else
      sync_d <= sync_act;
  end

  // ****************************************
  // address decode
  // ****************************************
  assign base = cfg[dram_dec_pkg::CFG_BASE_LSB +: 5];
  assign two_ranges = cfg[dram_dec_pkg::CFG_MODEL_LSB + dram_dec_pkg::MODEL_TWO_RANGES];
  assign big_chips = cfg[dram_dec_pkg::CFG_MODEL_LSB + dram_dec_pkg::MODEL_BIG_CHIPS];
  assign b7en = cfg[dram_dec_pkg::CFG_B7EN_BIT];
  assign par_en = cfg[dram_dec_pkg::CFG_PAR_BIT];
  // a 16-chip bank holds one or four 4K-word banks, doubled on 32-chip models
  assign size_banks = (big_chips ? 5'h04 : 5'h01) << two_ranges;
  assign bank_off = addr_now[dram_dec_pkg::BANK_LSB +: dram_dec_pkg::BANK_W] - base;
  // top bank inhibit: whole bank, or only the upper 2K when the lower half is on
  assign inhibit = ext_refresh_seen || (top_sel && (!b7en || bit12_hi));
  assign hit_now = !inhibit && (addr_now[dram_dec_pkg::BANK_LSB +: dram_dec_pkg::BANK_W] >= base)
                   && (bank_off < size_banks);

  // capture on the strobe leading edge, held for the cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cap_addr <= '0;
      cap_hit <= 1'b0;
      cap_low <= 1'b1;
    end
    else if (sync_act && !sync_d)
    begin
      cap_addr <= addr_now;
      cap_hit <= hit_now;
      cap_low <= !two_ranges || (bank_off < (size_banks >> 1));
    end
  end

  // ****************************************
  // cycle flops and requests
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      read_cycle_ff <= 1'b0;
      write_cycle_ff <= 1'b0;
    end
    else if (sync_act && !sync_d)
    begin
      read_cycle_ff <= hit_now && !wflag_act;
      write_cycle_ff <= hit_now && wflag_act;
    end
    else if (!sync_act)
    begin
      read_cycle_ff <= 1'b0;
      write_cycle_ff <= 1'b0;
    end
    else if (state == dram_dec_pkg::ST_HOLD && read_cycle_ff && dout_act)
      write_cycle_ff <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      byte_mode <= 1'b0;
    else if (dout_act && next_state == dram_dec_pkg::ST_COL && state != dram_dec_pkg::ST_COL)
      byte_mode <= wflag_act;
  end

  // column entry uses the live flags, not the copy from the last cycle
  assign byte_now = (state == dram_dec_pkg::ST_COL) ? byte_mode : wflag_act;
  assign wr_now = write_cycle_ff || (state == dram_dec_pkg::ST_HOLD);
  assign read_req = read_cycle_ff && din_act;
  assign write_req = write_cycle_ff && dout_act;
  assign acc_req = (read_req || write_req) && sync_act;

  // bus refresh is only watched for inhibit, never starts a refresh
  refresh_timer #(.INTERVAL_CYC(REFINT_CYC), .ROW_W(dram_dec_pkg::ROW_CNT_W)) u_ref (
    .aclk(aclk),
    .aresetn(aresetn),
    .done(ref_done),
    .ref_req(ref_req),
    .row(ref_row)
  );

  assign ref_done = (state == dram_dec_pkg::ST_REFRESH) && cnt_end;

  // ****************************************
  // timing sequencer
  // ****************************************
  assign cnt_end = (cnt == '0);

  always_comb
  begin
    next_state = state;
    case (state)
      dram_dec_pkg::ST_IDLE:
        if (ref_req && acc_req)
          next_state = dram_dec_pkg::ST_ARB;
        else if (ref_req)
          next_state = dram_dec_pkg::ST_REFRESH;
        else if (acc_req)
          next_state = dram_dec_pkg::ST_ROW;
      dram_dec_pkg::ST_ARB:
        if (cnt_end)
          next_state = dram_dec_pkg::ST_REFRESH;
      dram_dec_pkg::ST_REFRESH:
        if (cnt_end)
          next_state = dram_dec_pkg::ST_IDLE;
      dram_dec_pkg::ST_ROW:
        if (cnt_end)
          next_state = dram_dec_pkg::ST_COL;
      dram_dec_pkg::ST_COL:
        if (cnt_end)
          next_state = dram_dec_pkg::ST_REPLY;
      dram_dec_pkg::ST_REPLY:
        if (!(write_cycle_ff ? dout_act : din_act))
          next_state = sync_act ? dram_dec_pkg::ST_HOLD : dram_dec_pkg::ST_IDLE;
      dram_dec_pkg::ST_HOLD:
        if (!sync_act)
          next_state = dram_dec_pkg::ST_IDLE;
        else if (read_cycle_ff && !write_cycle_ff && dout_act)
          next_state = dram_dec_pkg::ST_COL;
      default:
        next_state = dram_dec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= dram_dec_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt <= '0;
    else if (next_state != state)
    begin
      case (next_state)
        dram_dec_pkg::ST_ARB: cnt <= dram_dec_pkg::CNT_W'(ARB_HOLD);
        dram_dec_pkg::ST_REFRESH: cnt <= dram_dec_pkg::CNT_W'(REF_HOLD);
        dram_dec_pkg::ST_ROW: cnt <= dram_dec_pkg::CNT_W'(dram_dec_pkg::RC_CYC - 1);
        dram_dec_pkg::ST_COL: cnt <= dram_dec_pkg::CNT_W'(dram_dec_pkg::CAS_CYC - 1);
        default: cnt <= '0;
      endcase
    end
    else if (!cnt_end)
      cnt <= cnt - dram_dec_pkg::CNT_W'(1);
  end

  // ****************************************
  // array strobes and address mux
  // ****************************************
  assign chip_addr = big_chips ? {cap_addr[14:13] - base[1:0], cap_addr[12:1]} : {2'h0, cap_addr[12:1]};
  assign row_part = big_chips ? chip_addr[6:0] : {1'b0, chip_addr[5:0]};
  assign col_part = big_chips ? chip_addr[13:7] : {1'b0, chip_addr[11:6]};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      row_strobe_lower_n <= 1'b1;
      row_strobe_upper_n <= 1'b1;
      col_strobe_a_n <= 1'b1;
      col_strobe_b_n <= 1'b1;
      hi_byte_write_n <= 1'b1;
      lo_byte_write_n <= 1'b1;
      row_col_addr_bus <= '0;
    end
    else
    begin
      if (next_state == dram_dec_pkg::ST_REFRESH)
      begin
        row_strobe_lower_n <= 1'b0;
        row_strobe_upper_n <= !two_ranges;
        row_col_addr_bus <= ref_row;
      end
      else if (next_state == dram_dec_pkg::ST_ROW)
      begin
        row_strobe_lower_n <= !cap_low;
        row_strobe_upper_n <= cap_low || !two_ranges;
        row_col_addr_bus <= row_part;
      end
      else if (next_state == dram_dec_pkg::ST_IDLE || next_state == dram_dec_pkg::ST_ARB)
      begin
        row_strobe_lower_n <= 1'b1;
        row_strobe_upper_n <= 1'b1;
      end
      else if (next_state == dram_dec_pkg::ST_COL)
        row_col_addr_bus <= col_part;
      col_strobe_a_n <= !((next_state inside {dram_dec_pkg::ST_COL, dram_dec_pkg::ST_REPLY,
                          dram_dec_pkg::ST_HOLD}) && cap_low);
      col_strobe_b_n <= !((next_state inside {dram_dec_pkg::ST_COL, dram_dec_pkg::ST_REPLY,
                          dram_dec_pkg::ST_HOLD}) && !cap_low);
      hi_byte_write_n <= !(next_state == dram_dec_pkg::ST_COL && wr_now
                         && (!byte_now || cap_addr[0]));
      lo_byte_write_n <= !(next_state == dram_dec_pkg::ST_COL && wr_now
                         && (!byte_now || !cap_addr[0]));
    end
  end

  // parity chips follow the data array strobes while par_en is set, and stay high when it is clear
  assign parity_row_strobe_n = !par_en || (row_strobe_lower_n && row_strobe_upper_n);
  assign parity_col_strobe_n = !par_en || (col_strobe_a_n && col_strobe_b_n);
  assign cycle_busy_lock_n = (state == dram_dec_pkg::ST_IDLE) || (state == dram_dec_pkg::ST_HOLD);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bus_reply_n <= 1'b1;
    else
      bus_reply_n <= !(next_state == dram_dec_pkg::ST_REPLY);
  end

  // ****************************************
  // register port
  // ****************************************
  assign awready = !aw_held;
  assign wready = !w_held;
  assign arready = !rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      else if (aw_held && w_held && !bvalid)
        aw_held <= 1'b0;
      if (wvalid && wready)
      begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      else if (aw_held && w_held && !bvalid)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg <= dram_dec_pkg::CFG_RST;
      bvalid <= 1'b0;
      bresp <= dram_dec_pkg::RESP_OKAY;
    end
    else if (aw_held && w_held && !bvalid)
    begin
      bvalid <= 1'b1;
      if (aw_addr_q[7:2] == dram_dec_pkg::CFG_OFF[7:2])
      begin
        bresp <= dram_dec_pkg::RESP_OKAY;
        if (w_strb_q[0])
          cfg[7:0] <= w_data_q[7:0];
        if (w_strb_q[1])
          cfg[8] <= w_data_q[8];
      end
      else if (aw_addr_q[7:2] == dram_dec_pkg::STAT_OFF[7:2])
        bresp <= dram_dec_pkg::RESP_OKAY;
      else
        bresp <= dram_dec_pkg::RESP_DECERR;
    end
    else if (bvalid && bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= dram_dec_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= '0;
      rresp <= dram_dec_pkg::RESP_OKAY;
      if (araddr[7:2] == dram_dec_pkg::CFG_OFF[7:2])
        rdata <= cfg;
      else if (araddr[7:2] == dram_dec_pkg::STAT_OFF[7:2])
      begin
        rdata[dram_dec_pkg::STAT_ROW_LSB +: 7] <= ref_row;
        rdata[dram_dec_pkg::STAT_HIT_BIT] <= cap_hit;
        rdata[dram_dec_pkg::STAT_BUSY_BIT] <= !cycle_busy_lock_n;
        rdata[dram_dec_pkg::STAT_WR_BIT] <= write_cycle_ff;
        rdata[dram_dec_pkg::STAT_EXT_BIT] <= ext_refresh_seen;
      end
      else
        rresp <= dram_dec_pkg::RESP_DECERR;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ref_start;
    $rose(state == dram_dec_pkg::ST_REFRESH);
  endsequence
  sequence s_arb_start;
    $rose(state == dram_dec_pkg::ST_ARB);
  endsequence

  a_ext_ref_block: assert property (ext_refresh_seen |-> !hit_now)
    else $error("decoder hit during external refresh");
  a_top_bank_block: assert property ((top_sel && !b7en) |-> !hit_now)
    else $error("hit on disabled top bank");
  a_upper2k_block: assert property ((top_sel && b7en && bit12_hi) |-> !hit_now)
    else $error("hit on upper 2K of top bank");
  a_write_waits_dout: assert property ((state == dram_dec_pkg::ST_IDLE && write_cycle_ff && !dout_act
                                        && !ref_req) |=> state != dram_dec_pkg::ST_ROW)
    else $error("write started before data-out strobe");
  a_refresh_length: assert property (s_ref_start |-> ##REF_HOLD (state == dram_dec_pkg::ST_REFRESH)
                                     ##1 (state == dram_dec_pkg::ST_IDLE))
    else $error("refresh sequence length wrong");
  a_arb_delay: assert property (s_arb_start |-> ##ARB_HOLD (state == dram_dec_pkg::ST_ARB)
                                ##1 (state == dram_dec_pkg::ST_REFRESH))
    else $error("arbitration delay wrong");
  a_start_cause: assert property ($rose(state != dram_dec_pkg::ST_IDLE) |-> $past(ref_req || acc_req))
    else $error("sequence started without request");
  a_reply_access: assert property (!bus_reply_n |-> (read_cycle_ff || write_cycle_ff))
    else $error("reply outside an access cycle");
  a_byte_sel: assert property ((hi_byte_write_n != lo_byte_write_n) |-> byte_mode)
    else $error("single byte select in word write");
  a_upper_row_model: assert property ((!row_strobe_upper_n) |-> two_ranges)
    else $error("upper row strobe on 16-chip model");
endmodule : dram_module_address_decode_control

// File: core/pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes the pins are asynchronous to aclk and quasi-static around strobes
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] meta;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pin_sync width must be positive");
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= RESET_VAL;
      synced <= RESET_VAL;
    end
    else
    begin
      meta <= pins;
      synced <= meta;
    end
  end
endmodule : pin_sync

// File: core/refresh_timer.sv
// refresh interval timer and refresh row counter
// assumes done is a one-cycle pulse at the end of each refresh sequence
`timescale 1ns/100ps
module refresh_timer #(
  parameter int INTERVAL_CYC = dram_dec_pkg::REFINT_CYC,
  parameter int ROW_W = dram_dec_pkg::ROW_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic done,
  output logic ref_req,
  output logic [ROW_W-1:0] row
);
  localparam int TW = $clog2(INTERVAL_CYC + 1);
  localparam logic [TW-1:0] LAST = TW'(INTERVAL_CYC - 1);
  logic [TW-1:0] tick_cnt;
  logic tick;

  if (INTERVAL_CYC < 2 || ROW_W < 1)
  begin : g_bad_param
    $error("refresh_timer needs an interval of two cycles or more");
  end

  assign tick = (tick_cnt == LAST);

  // ****************************************
  // interval and request
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_cnt <= '0;
    else if (tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + TW'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ref_req <= 1'b0;
    else if (tick)
      ref_req <= 1'b1;
    else if (done)
      ref_req <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      row <= '0;
    else if (done)
      row <= row + ROW_W'(1);
  end
endmodule : refresh_timer

// File: verif/bus_master_model.sv
// bus master model driving the backplane side of the dram module
// assumes the design samples these pins through its own synchronisers
`timescale 1ns/100ps
module bus_master_model (
  input wire logic aclk,
  input wire logic bus_reply_n,
  input wire logic row_strobe_lower_n,
  input wire logic row_strobe_upper_n,
  input wire logic col_strobe_a_n,
  input wire logic col_strobe_b_n,
  input wire logic hi_byte_write_n,
  input wire logic lo_byte_write_n,
  output logic [17:0] bus_addr_n,
  output logic bus_sync_n,
  output logic bus_din_n,
  output logic bus_dout_n,
  output logic bus_write_byte_flag_n,
  output logic bus_top_bank_sel_n,
  output logic bus_addr_bit12_n
);
  // ****************************************
  // one bus cycle; seen = upper range, reply, lower range, hi byte, lo byte
  // a range counts only with row and column strobe both low; a read with bw set is read-modify-write
  // ****************************************
  initial
  begin
    bus_addr_n = '1;
    {bus_sync_n, bus_din_n, bus_dout_n, bus_write_byte_flag_n, bus_top_bank_sel_n, bus_addr_bit12_n} = '1;
  end
  task xfer(input logic [17:0] a, input logic wr, input logic bw, output logic [4:0] seen);
    int i;
    seen = '0;
    @(posedge aclk);
    bus_addr_n <= ~a;
    bus_addr_bit12_n <= ~a[12];
    bus_top_bank_sel_n <= ~&a[17:13];
    bus_write_byte_flag_n <= ~wr;
    repeat (2) @(posedge aclk);
    bus_sync_n <= 1'b0;
    repeat (3) @(posedge aclk);
    if (wr)
    begin
      bus_dout_n <= 1'b0;
      bus_write_byte_flag_n <= ~bw;
    end
    else
      bus_din_n <= 1'b0;
    for (i = 0; i < 400 && !seen[3]; i++)
    begin
      @(posedge aclk);
      seen |= {~(row_strobe_upper_n | col_strobe_b_n), ~bus_reply_n, ~(row_strobe_lower_n | col_strobe_a_n),
               ~hi_byte_write_n, ~lo_byte_write_n};
    end
    if (!wr && bw)
    begin
      bus_din_n <= 1'b1;
      repeat (6) @(posedge aclk);
      bus_dout_n <= 1'b0;
      seen[3] = 1'b0;
      for (i = 0; i < 400 && !seen[3]; i++)
      begin
        @(posedge aclk);
        seen |= {~(row_strobe_upper_n | col_strobe_b_n), ~bus_reply_n, ~(row_strobe_lower_n | col_strobe_a_n),
                 ~hi_byte_write_n, ~lo_byte_write_n};
      end
    end
    bus_din_n <= 1'b1;
    bus_dout_n <= 1'b1;
    repeat (6) @(posedge aclk);
    bus_sync_n <= 1'b1;
    bus_addr_n <= a;
    bus_addr_bit12_n <= a[12];
    bus_top_bank_sel_n <= &a[17:13];
    bus_write_byte_flag_n <= wr;
    repeat (4) @(posedge aclk);
  endtask : xfer
endmodule : bus_master_model

// File: verif/tb.sv
// self-checking bench for the dram decode and control block
// assumes the design answers the AXI4-Lite port and the bus pins as handed over
`timescale 1ns/100ps
module tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, rd0;
  logic [3:0] wstrb;
  logic [4:0] sn;
  logic [1:0] bresp, rresp, rs;
  logic [17:0] bus_addr_n;
  logic bus_sync_n, bus_din_n, bus_dout_n, bus_write_byte_flag_n, bus_top_bank_sel_n, bus_addr_bit12_n;
  logic bus_refresh_req_n, bus_reply_n, row_strobe_lower_n, row_strobe_upper_n, col_strobe_a_n, col_strobe_b_n;
  logic hi_byte_write_n, lo_byte_write_n, parity_row_strobe_n, parity_col_strobe_n, cycle_busy_lock_n;
  logic ext_refresh_seen;
  logic [6:0] row_col_addr_bus;
  int n_fail, samples_checked;
  // ****************************************
  // instances and clock
  // ****************************************
  dram_module_address_decode_control #(.REFINT_CYC(200)) u_dram_module_address_decode_control (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .bus_addr_n, .bus_sync_n,
    .bus_din_n, .bus_dout_n, .bus_write_byte_flag_n, .bus_top_bank_sel_n, .bus_addr_bit12_n,
    .bus_refresh_req_n, .bus_reply_n, .row_strobe_lower_n, .row_strobe_upper_n, .col_strobe_a_n,
    .col_strobe_b_n, .hi_byte_write_n, .lo_byte_write_n, .row_col_addr_bus, .parity_row_strobe_n,
    .parity_col_strobe_n, .cycle_busy_lock_n, .ext_refresh_seen);
  bus_master_model u_bus_master_model (.aclk, .bus_reply_n, .row_strobe_lower_n, .row_strobe_upper_n,
    .col_strobe_a_n, .col_strobe_b_n, .hi_byte_write_n,
    .lo_byte_write_n, .bus_addr_n, .bus_sync_n, .bus_din_n, .bus_dout_n, .bus_write_byte_flag_n,
    .bus_top_bank_sel_n, .bus_addr_bit12_n);
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hf, 3'h7};
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask : axi_rd
  task t_regs;
    axi_wr(8'h00, 32'h42, rs);
    chk("cfg_bresp", 0, rs);
    axi_rd(8'h00, rd, rs);
    chk("cfg_read", 32'h42, rd & 32'h1ff);
    axi_wr(8'h08, 0, rs);
    chk("bad_bresp", 3, rs);
    axi_rd(8'h08, rd, rs);
    chk("bad_rresp", 3, rs);
  endtask : t_regs
  task t_access;
    u_bus_master_model.xfer(18'h06000, 0, 0, sn);
    chk("read_hit", 4'hc, sn);
    u_bus_master_model.xfer(18'h0a000, 1, 0, sn);
    chk("word_write", 4'hf, sn);
    u_bus_master_model.xfer(18'h06001, 1, 1, sn);
    chk("byte_write", 4'he, sn);
    u_bus_master_model.xfer(18'h0c000, 0, 0, sn);
    chk("above_range", 0, sn);
    u_bus_master_model.xfer(18'h02000, 0, 0, sn);
    chk("below_range", 0, sn);
  endtask : t_access
  task t_extref;
    @(posedge aclk);
    bus_refresh_req_n <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("ext_seen", 1, ext_refresh_seen);
    u_bus_master_model.xfer(18'h06000, 0, 0, sn);
    chk("ext_inhibit", 0, sn);
    bus_refresh_req_n <= 1'b1;
  endtask : t_extref
  task t_top;
    axi_wr(8'h00, 32'h1f, rs);
    u_bus_master_model.xfer(18'h3e000, 0, 0, sn);
    chk("top_off", 0, sn);
    axi_wr(8'h00, 32'h9f, rs);
    u_bus_master_model.xfer(18'h3e000, 0, 0, sn);
    chk("top_low", 4'hc, sn);
    u_bus_master_model.xfer(18'h3f000, 0, 0, sn);
    chk("top_high", 0, sn);
  endtask : t_top
  task t_two;
    axi_wr(8'h00, 32'h122, rs);
    u_bus_master_model.xfer(18'h04000, 0, 0, sn);
    chk("lower_range", 5'h0c, sn);
    u_bus_master_model.xfer(18'h06000, 0, 0, sn);
    chk("upper_range", 5'h18, sn);
    u_bus_master_model.xfer(18'h06000, 0, 1, sn);
    chk("rmw_upper", 5'h1b, sn);
    axi_rd(8'h04, rd, rs);
    chk("status_hit", 1, rd[dram_dec_pkg::STAT_HIT_BIT]);
  endtask : t_two
  task t_refresh;
    axi_rd(8'h04, rd0, rs);
    repeat (1000) @(posedge aclk);
    axi_rd(8'h04, rd, rs);
    rd = (rd - rd0) & 32'h7f;
    chk("row_steps", 1, rd >= 5 && rd <= 6);
    while (!cycle_busy_lock_n) @(posedge aclk);
    while (cycle_busy_lock_n) @(posedge aclk);
    rd = {cycle_busy_lock_n, row_strobe_lower_n, row_strobe_upper_n, parity_row_strobe_n, col_strobe_a_n};
    chk("refresh_strobes", 5'h01, rd);
  endtask : t_refresh
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    bus_refresh_req_n = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset_idle", 32'h7, {bus_reply_n, row_strobe_lower_n, awready});
    t_regs;
    t_access;
    t_extref;
    t_top;
    t_two;
    t_refresh;
    conclude;
  end
  initial
  begin
    #200000;
    n_fail++;
    conclude;
  end
endmodule : tb
